/* File: pmu_mode_power_outputs.sv */
/*
  Four power control pins whose levels are picked per power-management
  mode from two software-written control registers, with activity-timer
  expiry clearing the bit groups of the disk, floppy and parallel-I/O pins.
  Assumes mode code and expiry strobes come from logic on pclk, and an
  APB master on the same clock.
*/
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pmu_mode_power_outputs (
  input wire logic pclk,
  input wire logic presetn,
  input wire pmu_power_pkg::apb_req_t apb_req,
  output var pmu_power_pkg::apb_rsp_t apb_rsp,
  input wire logic [2:0] present_mode,
  input wire pmu_power_pkg::timer_expiry_t timer_expiry,
  output var pmu_power_pkg::power_pins_t power_pins
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] disk_power_out_ctrl;
    logic [7:0] floppy_pio_power_out_ctrl;
    pmu_power_pkg::power_pins_t pins;
    pmu_power_pkg::apb_rsp_t rsp;
  } state_t;

  localparam state_t STATE_RESET = '{
    disk_power_out_ctrl: pmu_power_pkg::DISK_CTRL_RESET,
    floppy_pio_power_out_ctrl: pmu_power_pkg::FLOPPY_PIO_CTRL_RESET,
    pins: pmu_power_pkg::PINS_RESET,
    rsp: pmu_power_pkg::APB_RSP_RESET
  };

  state_t state;
  state_t next_state;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Both PLL modes share the full-speed setting; unknown codes fall back to it
  function automatic pmu_power_pkg::mode_sel_t decode_mode(input logic [2:0] code);
    pmu_power_pkg::mode_sel_t sel;
    sel = pmu_power_pkg::SEL_FULLSPEED;
    case (code)
      pmu_power_pkg::MODE_HIGH_PLL,
      pmu_power_pkg::MODE_LOW_PLL: sel = pmu_power_pkg::SEL_FULLSPEED;
      pmu_power_pkg::MODE_DOZE: sel = pmu_power_pkg::SEL_DOZE;
      pmu_power_pkg::MODE_SLEEP: sel = pmu_power_pkg::SEL_SLEEP;
      pmu_power_pkg::MODE_SUSPEND: sel = pmu_power_pkg::SEL_SUSPEND;
      default: sel = pmu_power_pkg::SEL_FULLSPEED;
    endcase
    return sel;
  endfunction

  // Picks the group bit for the present mode
  function automatic logic pick_level(input logic [3:0] group, input pmu_power_pkg::mode_sel_t sel);
    logic level;
    level = group[pmu_power_pkg::FULLSPEED_BIT];
    unique case (sel)
      pmu_power_pkg::SEL_FULLSPEED: level = group[pmu_power_pkg::FULLSPEED_BIT];
      pmu_power_pkg::SEL_DOZE: level = group[pmu_power_pkg::DOZE_BIT];
      pmu_power_pkg::SEL_SLEEP: level = group[pmu_power_pkg::SLEEP_BIT];
      pmu_power_pkg::SEL_SUSPEND: level = group[pmu_power_pkg::SUSPEND_BIT];
    endcase
    return level;
  endfunction

  pmu_power_pkg::mode_sel_t mode_sel;
  assign mode_sel = decode_mode(present_mode);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic setup_phase;
  logic access_done;
  logic hit_disk;
  logic hit_fpio;

  assign setup_phase = apb_req.psel && !apb_req.penable;
  assign access_done = apb_req.psel && apb_req.penable && state.rsp.pready;
  assign hit_disk = apb_req.paddr == pmu_power_pkg::DISK_CTRL_ADDR;
  assign hit_fpio = apb_req.paddr == pmu_power_pkg::FLOPPY_PIO_CTRL_ADDR;

  always_comb begin
    next_state = state;

    // No wait states: answer is raised in the first access cycle
    next_state.rsp.pready = setup_phase;
    next_state.rsp.pslverr = setup_phase && !(hit_disk || hit_fpio);
    next_state.rsp.prdata = 32'h0000_0000;
    if (setup_phase && !apb_req.pwrite) begin
      if (hit_disk) begin
        next_state.rsp.prdata = {24'h00_0000, state.disk_power_out_ctrl};
      end else if (hit_fpio) begin
        next_state.rsp.prdata = {24'h00_0000, state.floppy_pio_power_out_ctrl};
      end
    end
    if (access_done) begin
      next_state.rsp.prdata = state.rsp.prdata;
    end

    // Software writes, then timer clears, so an expiry is never lost
    if (access_done && apb_req.pwrite && hit_disk) begin
      next_state.disk_power_out_ctrl = apb_req.pwdata[7:0];
    end
    if (access_done && apb_req.pwrite && hit_fpio) begin
      next_state.floppy_pio_power_out_ctrl = apb_req.pwdata[7:0];
    end
    if (timer_expiry.hdd_expired) begin
      next_state.disk_power_out_ctrl = next_state.disk_power_out_ctrl
        & ~pmu_power_pkg::UPPER_GROUP_MASK;
    end
    if (timer_expiry.pio_expired) begin
      next_state.floppy_pio_power_out_ctrl = next_state.floppy_pio_power_out_ctrl
        & ~pmu_power_pkg::UPPER_GROUP_MASK;
    end
    if (timer_expiry.floppy_expired) begin
      next_state.floppy_pio_power_out_ctrl = next_state.floppy_pio_power_out_ctrl
        & ~pmu_power_pkg::LOWER_GROUP_MASK;
    end

    // Pins follow the stored bits, one edge after a mode change and two edges after a write
    next_state.pins.hdd_power_out = pick_level(
      state.disk_power_out_ctrl[pmu_power_pkg::UPPER_GROUP_LSB +: 4], mode_sel);
    next_state.pins.inverted_power_out = !pick_level(
      state.disk_power_out_ctrl[pmu_power_pkg::LOWER_GROUP_LSB +: 4], mode_sel);
    next_state.pins.pio_power_out = pick_level(
      state.floppy_pio_power_out_ctrl[pmu_power_pkg::UPPER_GROUP_LSB +: 4], mode_sel);
    next_state.pins.floppy_power_out = pick_level(
      state.floppy_pio_power_out_ctrl[pmu_power_pkg::LOWER_GROUP_LSB +: 4], mode_sel);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign apb_rsp = state.rsp;
  assign power_pins = state.pins;

endmodule

`default_nettype wire

/* File: pmu_power_pkg.sv */
/*
  Constants, types and register map for the mode-driven power output pins.
  Assumes a 32-bit APB slave port and a present-mode code from the
  power-management sequencer on the same clock.
*/
// What this block does
// - Disk output follows first register bit 7/6/5/4 for suspend/sleep/doze/full speed.
// - Inverted output drives complement of first register bit 3/2/1/0 per mode.
// - Parallel-I/O output follows second register bit 7/6/5/4 per mode.
// - Floppy output follows second register bit 3/2/1/0 per mode.
// - One full-speed bit serves both high-speed and low-speed PLL modes.
// - Disk output is Low after power-on.
// - Inverted output is High after power-on.
// - Floppy and parallel-I/O outputs are Low after power-on.
// - Disk timer expiry clears first register bits 7 to 4.
// - Parallel-I/O timer expiry clears second register bits 7 to 4.
// - Floppy timer expiry clears second register bits 3 to 0.

package pmu_power_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] DISK_CTRL_INDEX = 8'h00_ab;
  localparam logic [7:0] FLOPPY_PIO_CTRL_INDEX = 8'h00_ac;
  localparam logic [ADDR_W-1:0] DISK_CTRL_ADDR = {2'b00, DISK_CTRL_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] FLOPPY_PIO_CTRL_ADDR = {2'b00, FLOPPY_PIO_CTRL_INDEX, 2'b00};
  localparam logic [7:0] DISK_CTRL_RESET = 8'h00_00;
  localparam logic [7:0] FLOPPY_PIO_CTRL_RESET = 8'h00_00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned UPPER_GROUP_LSB = 4;
  localparam int unsigned LOWER_GROUP_LSB = 0;
  localparam logic [7:0] UPPER_GROUP_MASK = 8'h00_f0;
  localparam logic [7:0] LOWER_GROUP_MASK = 8'h00_0f;

  // ----------------------------------------
  // Present-mode codes from the sequencer
  // ----------------------------------------
  localparam logic [2:0] MODE_HIGH_PLL = 3'h0;
  localparam logic [2:0] MODE_LOW_PLL = 3'h4;
  localparam logic [2:0] MODE_DOZE = 3'h1;
  localparam logic [2:0] MODE_SLEEP = 3'h3;
  localparam logic [2:0] MODE_SUSPEND = 3'h2;

  // Decoded mode, one-hot
  typedef enum logic [3:0] {
    SEL_FULLSPEED = 4'b0001,
    SEL_DOZE = 4'b0010,
    SEL_SLEEP = 4'b0100,
    SEL_SUSPEND = 4'b1000
  } mode_sel_t;

  // Bit offset within a four-bit group for each mode
  localparam logic [1:0] FULLSPEED_BIT = 2'h0;
  localparam logic [1:0] DOZE_BIT = 2'h1;
  localparam logic [1:0] SLEEP_BIT = 2'h2;
  localparam logic [1:0] SUSPEND_BIT = 2'h3;

  // ----------------------------------------
  // Pin levels and reset values
  // ----------------------------------------
  typedef struct packed {
    logic hdd_power_out;
    logic inverted_power_out;
    logic pio_power_out;
    logic floppy_power_out;
  } power_pins_t;

  localparam power_pins_t PINS_RESET = '{
    hdd_power_out: 1'b0,
    inverted_power_out: 1'b1,
    pio_power_out: 1'b0,
    floppy_power_out: 1'b0
  };

  typedef struct packed {
    logic hdd_expired;
    logic floppy_expired;
    logic pio_expired;
  } timer_expiry_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  localparam apb_rsp_t APB_RSP_RESET = '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};

endpackage

/* File: pmu_mode_power_outputs_monitor.sv */
/* Port assertions for the mode-driven power output block.
   Assumes it is bound to pmu_mode_power_outputs. */
`timescale 1ns/1ps
`default_nettype none
module pmu_mode_power_outputs_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire pmu_power_pkg::apb_req_t apb_req,
  input wire pmu_power_pkg::apb_rsp_t apb_rsp,
  input wire logic [2:0] present_mode,
  input wire pmu_power_pkg::timer_expiry_t timer_expiry,
  input wire pmu_power_pkg::power_pins_t power_pins
);
  // ----------------
  // Checks
  // ----------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic any_exp;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & apb_rsp.pready;
  assign any_exp = |timer_expiry;
  reset_pins_a: assert property ($rose(presetn) |-> power_pins == pmu_power_pkg::PINS_RESET)
    else $error("pins off reset levels");
  ready_next_a: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready in access cycle");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("error without ready");
  rdata_upper_a: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  hdd_clear_a: assert property (timer_expiry.hdd_expired ##1 !wr |=> !power_pins.hdd_power_out)
    else $error("disk pin not cleared");
  pio_clear_a: assert property (timer_expiry.pio_expired ##1 !wr |=> !power_pins.pio_power_out)
    else $error("pio pin not cleared");
  floppy_clear_a: assert property (timer_expiry.floppy_expired ##1 !wr |=> !power_pins.floppy_power_out)
    else $error("floppy pin not cleared");
  pin_cause_a: assert property ($changed(power_pins) |->
    $past(present_mode) != $past(present_mode, 2) || $past(wr, 2) || $past(any_exp, 2))
    else $error("pin moved without cause");
  cover property (wr);
  cover property (apb_rsp.pslverr);
  cover property (timer_expiry.hdd_expired);
endmodule
`default_nettype wire

/* File: pmu_power_switch_model.sv */
/* External power switches fed by the four pins.
   Assumes pins are registered on pclk. */
`timescale 1ns/1ps
`default_nettype none
module pmu_power_switch_model (
  input wire logic pclk,
  input wire pmu_power_pkg::power_pins_t power_pins,
  output logic [3:0] rail_on
);
  // Inverted pin is an active-low enable
  always_ff @(posedge pclk) begin
    rail_on <= {power_pins.hdd_power_out, !power_pins.inverted_power_out,
                power_pins.pio_power_out, power_pins.floppy_power_out};
  end
endmodule
`default_nettype wire

/* File: tb_pmu_mode_power_outputs.sv */
/* Self-checking bench for the power output block.
   Assumes the package, design, monitor and switch model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_pmu_mode_power_outputs;
  logic pclk = 0;
  logic presetn = 0;
  pmu_power_pkg::apb_req_t req = '0;
  pmu_power_pkg::apb_rsp_t rsp;
  logic [2:0] mode = 3'h0;
  pmu_power_pkg::timer_expiry_t exp_in = '0;
  pmu_power_pkg::power_pins_t pins;
  logic [3:0] rail_on;
  logic pin_chk = 0;
  logic rail_chk = 0;
  logic [32:0] notes [$];
  logic [32:0] got;
  logic [7:0] r3 = 8'h00;
  logic [7:0] r4 = 8'h00;
  logic [2:0] modes [5] = '{pmu_power_pkg::MODE_HIGH_PLL, pmu_power_pkg::MODE_LOW_PLL,
    pmu_power_pkg::MODE_DOZE, pmu_power_pkg::MODE_SLEEP, pmu_power_pkg::MODE_SUSPEND};
  int idx [5] = '{0, 0, 1, 2, 3};
  int n_fail = 0;
  int checked = 0;
  always #2 pclk = ~pclk;
  pmu_mode_power_outputs pmu_mode_power_outputs_i (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .present_mode(mode), .timer_expiry(exp_in), .power_pins(pins));
  pmu_power_switch_model pmu_power_switch_model_i (.pclk(pclk), .power_pins(pins), .rail_on(rail_on));
  // ----------------
  // Result watcher
  // ----------------
  always @(posedge pclk) begin
    rail_chk <= pin_chk;
    if ((rsp.pready && !req.pwrite) || pin_chk || rail_chk) begin
      got = pin_chk ? {29'h0, pins} : rail_chk ? {29'h0, rail_on} : {rsp.pslverr, rsp.prdata};
      checked++;
      if (notes.size() == 0 || got !== notes[0]) begin
        n_fail++;
        $display("mismatch at %0t: got %h", $time, got);
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
    if (!w) notes.push_back(e);
    req.psel <= 1;
    req.penable <= 0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h0, d};
    @(posedge pclk);
    req.penable <= 1;
    do @(posedge pclk); while (!rsp.pready);
    req.psel <= 0;
    req.penable <= 0;
    @(posedge pclk);
  endtask
  task automatic pins_at(input logic [2:0] m, input int i);
    mode <= m;
    notes.push_back({29'h0, r3[4 + i], ~r3[i], r4[4 + i], r4[i]});
    // Switch rails are on exactly where the selected bit is set
    notes.push_back({29'h0, r3[4 + i], r3[i], r4[4 + i], r4[i]});
    @(posedge pclk);
    pin_chk <= 1;
    @(posedge pclk);
    pin_chk <= 0;
  endtask
  task automatic final_report;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(32'h2063_07c7));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    pins_at(modes[4], 3);
    apb(0, pmu_power_pkg::DISK_CTRL_ADDR, 8'h00, 33'h0);
    apb(0, pmu_power_pkg::FLOPPY_PIO_CTRL_ADDR, 8'h00, 33'h0);
    apb(0, 12'h004, 8'h00, {1'b1, 32'h0});
    repeat (4) begin
      r3 = 8'($urandom);
      r4 = 8'($urandom);
      apb(1, pmu_power_pkg::DISK_CTRL_ADDR, r3, 33'h0);
      apb(1, pmu_power_pkg::FLOPPY_PIO_CTRL_ADDR, r4, 33'h0);
      for (int k = 0; k < 5; k++) pins_at(modes[k], idx[k]);
      // Unused mode codes fall back to the full-speed bits
      pins_at(3'h5 + 3'($urandom_range(2)), 0);
    end
    r3 = 8'hff;
    r4 = 8'hff;
    apb(1, pmu_power_pkg::DISK_CTRL_ADDR, r3, 33'h0);
    apb(1, pmu_power_pkg::FLOPPY_PIO_CTRL_ADDR, r4, 33'h0);
    // Each timer strobes only its own pin group
    for (int k = 0; k < 3; k++) begin
      exp_in <= pmu_power_pkg::timer_expiry_t'(3'b100 >> k);
      @(posedge pclk);
      exp_in <= '0;
      r3 = (k == 0) ? (r3 & 8'h0f) : r3;
      r4 = (k == 1) ? (r4 & 8'hf0) : (k == 2) ? (r4 & 8'h0f) : r4;
      pins_at(modes[4], 3);
      apb(0, pmu_power_pkg::DISK_CTRL_ADDR, 8'h00, {25'h0, r3});
      apb(0, pmu_power_pkg::FLOPPY_PIO_CTRL_ADDR, 8'h00, {25'h0, r4});
    end
    final_report();
  end
  initial begin
    repeat (4000) @(posedge pclk);
    n_fail++;
    final_report();
  end
endmodule
bind pmu_mode_power_outputs pmu_mode_power_outputs_monitor pmu_mode_power_outputs_monitor_i (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp), .present_mode(present_mode),
  .timer_expiry(timer_expiry), .power_pins(power_pins));
`default_nettype wire
